// file: hw/cavpb_defines.svh
// What this block does
// - Buffered blocks play at a fixed single-speed rate, whatever the fill rate.
// - Firmware pulses the increment input per decoded block; valid count rises by one.
// - Valid count drops by one when a whole block has been shifted out.
// - Each finished block makes an event; its sticky flag sets only when masked in.
// - Buffer under-run mutes both channels automatically.
// - Block pointer names the playing block and advances after it completes.
// - Block pointer wraps to the buffer start after the buffer's last block.
// - In CAV mode the three audio pins are outputs carrying buffered audio, bypassed DSP audio or idle levels.
// - Outside CAV mode the three audio pins act as general purpose pins.
// - Format 12h selects 16-bit EIAJ, 92h selects 18-bit EIAJ.
// - Format 70h selects 16-bit I2S, F0h 18-bit I2S; top bit selects 18-bit.
// - Bypass bit routes DSP serial inputs straight to the audio pins.
// - DAC control bits 7 and 6 mute left and right in CAV and bypass.
// - Power-on and software reset set both mute bits.
// - DAC control bits 2:1 pick stereo, mono right, mono left or swap.
// - Start-play set and bypass clear sends buffered blocks to the audio pins.
// - Mono modes copy one channel to both, CAV only; stereo and swap also bypass.
// - With digital audio enabled, the same buffered audio also leaves the digital pin.
`ifndef CAVPB_DEFINES_SVH
`define CAVPB_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define CAVPB_ADDR_COUNT   8'h48
`define CAVPB_ADDR_BLOCK   8'h4A
`define CAVPB_ADDR_FORMAT  8'h4C
`define CAVPB_ADDR_DACCTL  8'h4D
`define CAVPB_ADDR_CLKCTL  8'h4E

// ****************************************************************
// Field positions
// ****************************************************************
`define CAVPB_FMT_W18      7
`define CAVPB_FMT_DLY1     6
`define CAVPB_FMT_LJUST    5
`define CAVPB_FMT_LEN_HI   4
`define CAVPB_FMT_LEN_LO   3
`define CAVPB_FMT_LSBF     2
`define CAVPB_FMT_LHIGH    1
`define CAVPB_FMT_BCKF     0
`define CAVPB_DAC_LMUTE    7
`define CAVPB_DAC_RMUTE    6
`define CAVPB_DAC_MODE_HI  2
`define CAVPB_DAC_MODE_LO  1
`define CAVPB_DAC_SPA      0
`define CAVPB_CLK_BYPASS   6
`define CAVPB_CLK_DIGITAL_AUDIO_ENABLE     5

// ****************************************************************
// Encodings, reset values and write masks
// ****************************************************************
`define CAVPB_MODE_STEREO  2'h0
`define CAVPB_MODE_MONO_R  2'h1
`define CAVPB_MODE_MONO_L  2'h2
`define CAVPB_MODE_SWAP    2'h3
`define CAVPB_RST_COUNT    8'h00
`define CAVPB_RST_BLOCK    8'h00
`define CAVPB_RST_FORMAT   8'h12
`define CAVPB_RST_DACCTL   8'hC0
`define CAVPB_RST_CLKCTL   8'h01
`define CAVPB_MASK_DACCTL  8'hC7
`define CAVPB_MASK_CLKCTL  8'h63

// ****************************************************************
// Buffer geometry and timing
// ****************************************************************
`define CAVPB_WORDS_PER_BLK 10'h24C
`define CAVPB_BUF_FIRST_BLK 8'h00
`define CAVPB_BUF_LAST_BLK  8'hFF
`define CAVPB_BCK_HALF      4'h4

`endif

// file: hw/cavpb_pkg.sv
package cavpb_pkg;

  typedef struct packed {
    logic [17:0] left;
    logic [17:0] right;
  } cavpb_sample_t;

  typedef struct packed {
    logic [7:0] fmt;
    logic [7:0] dac;
    logic [7:0] clk;
    logic       cav;
    logic       run;
    logic [2:0] gpio_out;
    logic [2:0] gpio_oen_n;
  } cavpb_cfg_t;

  typedef enum logic [1:0] {LK_GPIO, LK_IDLE, LK_PLAY, LK_BYPASS} cavpb_lmode_t;

  typedef struct packed {
    cavpb_cfg_t    cfg;
    logic [7:0]    count;
    logic [7:0]    ptr;
    logic [7:0]    rdata;
    logic          mem_req;
    logic [17:0]   mem_addr;
    logic [9:0]    fetch_idx;
    logic          ahead;
    logic          staged;
    logic          data_tgl;
    cavpb_sample_t xfer;
    logic          ack_s1;
    logic          ack_s2;
    logic          done_s1;
    logic          done_s2;
    logic          done_s3;
    logic [9:0]    done_cnt;
    logic          blk_evt;
    logic          flag;
    logic [2:0]    gpin_s1;
    logic [2:0]    gpin_s2;
  } cavpb_sys_t;

  typedef struct packed {
    cavpb_cfg_t    cfg_s1;
    cavpb_cfg_t    cfg_s2;
    logic [2:0]    dsp_s1;
    logic [2:0]    dsp_s2;
    logic          tgl_s1;
    logic          tgl_s2;
    logic          ack;
    logic          done_tgl;
    cavpb_lmode_t  mode;
    logic [3:0]    div;
    logic          phase;
    logic [4:0]    bit_idx;
    logic          chan;
    cavpb_sample_t smp;
    logic          smp_ok;
    logic          wck;
    logic          bck;
    logic          dat;
    logic          dau;
    logic [2:0]    oen_n;
  } cavpb_link_t;

endpackage

// file: hw/cavpb_top.sv
`timescale 1ns/1ps
`include "cavpb_defines.svh"

module cavpb_top import cavpb_pkg::*; (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        audio_clk_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        increment_block_count_i,
  input  wire logic        soft_reset_i,
  input  wire logic        cav_mode_i,
  input  wire logic        dac_block_done_mask_i,
  input  wire logic        dac_block_done_clear_i,
  output logic             dac_block_done_o,
  output logic             dac_block_done_flag_o,
  output logic             mem_req_o,
  output logic      [17:0] mem_addr_o,
  input  wire logic        mem_ack_i,
  input  wire logic [35:0] mem_data_i,
  input  wire logic        dsp_lrck_i,
  input  wire logic        dsp_bck_i,
  input  wire logic        dsp_data_i,
  input  wire logic [2:0]  gpio_out_i,
  input  wire logic [2:0]  gpio_oen_n_i,
  output logic      [2:0]  gpio_in_o,
  input  wire logic        audio_word_clock_pin_i,
  input  wire logic        audio_bit_clock_pin_i,
  input  wire logic        audio_serial_data_pin_i,
  output logic             audio_word_clock_out_o,
  output logic             audio_word_clock_oen_n_o,
  output logic             audio_bit_clock_out_o,
  output logic             audio_bit_clock_oen_n_o,
  output logic             audio_serial_data_out_o,
  output logic             audio_serial_data_oen_n_o,
  output logic             digital_audio_output_pin_o
);

  cavpb_sys_t  s_q;
  cavpb_sys_t  s_n;
  cavpb_link_t l_q;
  cavpb_link_t l_n;

  function automatic logic [7:0] cavpb_next_blk(input logic [7:0] b);
    cavpb_next_blk = (b == `CAVPB_BUF_LAST_BLK) ? `CAVPB_BUF_FIRST_BLK : b + 8'h01;
  endfunction

  // ****************************************************************
  // System clock domain: registers, block tracking, fetch
  // ****************************************************************
  logic       fetch_ok;
  logic       blk_inc;
  logic       blk_dec;
  logic [7:0] dac_wr;

  always_comb begin
    s_n      = s_q;
    blk_inc  = increment_block_count_i;
    blk_dec  = 1'b0;
    dac_wr   = reg_wdata_i & `CAVPB_MASK_DACCTL;
    s_n.ack_s1  = l_q.ack;
    s_n.ack_s2  = s_q.ack_s1;
    s_n.done_s1 = l_q.done_tgl;
    s_n.done_s2 = s_q.done_s1;
    s_n.done_s3 = s_q.done_s2;
    s_n.gpin_s1 = {audio_word_clock_pin_i, audio_bit_clock_pin_i, audio_serial_data_pin_i};
    s_n.gpin_s2 = s_q.gpin_s1;
    s_n.blk_evt = 1'b0;
    s_n.cfg.cav        = cav_mode_i;
    s_n.cfg.gpio_out   = gpio_out_i;
    s_n.cfg.gpio_oen_n = gpio_oen_n_i;
    s_n.cfg.run        = s_q.cfg.dac[`CAVPB_DAC_SPA] & ~s_q.cfg.clk[`CAVPB_CLK_BYPASS];

    // A frame that carried data has left the pins; a full block of them retires the block
    if (s_q.done_s2 != s_q.done_s3) begin
      if (s_q.done_cnt == `CAVPB_WORDS_PER_BLK - 10'h001) begin
        s_n.done_cnt = 10'h000;
        s_n.ptr      = cavpb_next_blk(s_q.ptr);
        s_n.ahead    = 1'b0;
        blk_dec      = 1'b1;
        s_n.blk_evt  = 1'b1;
      end else begin
        s_n.done_cnt = s_q.done_cnt + 10'h001;
      end
    end

    // Set wins over clear
    if (s_n.blk_evt && dac_block_done_mask_i) begin
      s_n.flag = 1'b1;
    end else if (dac_block_done_clear_i) begin
      s_n.flag = 1'b0;
    end

    if (reg_wr_i && reg_addr_i == `CAVPB_ADDR_COUNT) begin
      s_n.count = reg_wdata_i;
    end else if (blk_inc && !blk_dec) begin
      s_n.count = s_q.count + 8'h01;
    end else if (blk_dec && !blk_inc && s_q.count != 8'h00) begin
      s_n.count = s_q.count - 8'h01;
    end

    if (reg_wr_i) begin
      case (reg_addr_i)
        `CAVPB_ADDR_BLOCK: begin
          s_n.ptr       = reg_wdata_i;
          s_n.fetch_idx = 10'h000;
          s_n.done_cnt  = 10'h000;
          s_n.ahead     = 1'b0;
        end
        `CAVPB_ADDR_FORMAT: s_n.cfg.fmt = reg_wdata_i;
        `CAVPB_ADDR_DACCTL: s_n.cfg.dac = dac_wr;
        `CAVPB_ADDR_CLKCTL: s_n.cfg.clk = reg_wdata_i & `CAVPB_MASK_CLKCTL;
        default: ;
      endcase
    end
    if (soft_reset_i) begin
      s_n.cfg.dac[`CAVPB_DAC_LMUTE] = 1'b1;
      s_n.cfg.dac[`CAVPB_DAC_RMUTE] = 1'b1;
    end

    if (reg_rd_i) begin
      case (reg_addr_i)
        `CAVPB_ADDR_COUNT:  s_n.rdata = s_q.count;
        `CAVPB_ADDR_BLOCK:  s_n.rdata = s_q.ptr;
        `CAVPB_ADDR_FORMAT: s_n.rdata = s_q.cfg.fmt;
        `CAVPB_ADDR_DACCTL: s_n.rdata = s_q.cfg.dac;
        `CAVPB_ADDR_CLKCTL: s_n.rdata = s_q.cfg.clk;
        default:            s_n.rdata = 8'h00;
      endcase
    end

    // Running one block ahead needs a second valid block behind the playing one
    fetch_ok = s_q.ahead ? (s_q.count > 8'h01) : (s_q.count != 8'h00);
    if (s_q.mem_req) begin
      if (mem_ack_i) begin
        s_n.mem_req  = 1'b0;
        s_n.xfer     = mem_data_i;
        s_n.data_tgl = ~s_q.data_tgl;
        s_n.staged   = 1'b1;
        if (s_q.fetch_idx == `CAVPB_WORDS_PER_BLK - 10'h001) begin
          s_n.fetch_idx = 10'h000;
          s_n.ahead     = 1'b1;
        end else begin
          s_n.fetch_idx = s_q.fetch_idx + 10'h001;
        end
      end
    end else if (s_q.staged) begin
      if (s_q.ack_s2 == s_q.data_tgl) begin
        s_n.staged = 1'b0;
      end
    end else if (s_q.cfg.run && s_q.cfg.cav && fetch_ok) begin
      s_n.mem_req  = 1'b1;
      s_n.mem_addr = {(s_q.ahead ? cavpb_next_blk(s_q.ptr) : s_q.ptr), s_q.fetch_idx};
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q         <= '0;
      s_q.count   <= `CAVPB_RST_COUNT;
      s_q.ptr     <= `CAVPB_RST_BLOCK;
      s_q.cfg.fmt <= `CAVPB_RST_FORMAT;
      s_q.cfg.dac <= `CAVPB_RST_DACCTL;
      s_q.cfg.clk <= `CAVPB_RST_CLKCTL;
      s_q.cfg.gpio_oen_n <= 3'h7;
    end else begin
      s_q <= s_n;
    end
  end

  // ****************************************************************
  // Link clock domain: serial framing, bypass and pin muxing
  // ****************************************************************
  cavpb_cfg_t         cfg;
  logic [5:0]         nbits;
  logic [5:0]         wbits;
  logic signed [6:0]  off;
  logic signed [6:0]  pos;
  logic signed [6:0]  sel;
  logic [17:0]        chd;
  logic               chmute;
  logic               swap;
  logic               serial_bit;

  always_comb begin
    l_n        = l_q;
    l_n.cfg_s1 = s_q.cfg;
    l_n.cfg_s2 = l_q.cfg_s1;
    l_n.dsp_s1 = {dsp_lrck_i, dsp_bck_i, dsp_data_i};
    l_n.dsp_s2 = l_q.dsp_s1;
    l_n.tgl_s1 = s_q.data_tgl;
    l_n.tgl_s2 = l_q.tgl_s1;
    cfg        = l_q.cfg_s2;
    swap       = cfg.dac[`CAVPB_DAC_MODE_HI:`CAVPB_DAC_MODE_LO] == `CAVPB_MODE_SWAP;

    if (!cfg.cav) begin
      l_n.mode = LK_GPIO;
    end else if (cfg.clk[`CAVPB_CLK_BYPASS]) begin
      l_n.mode = LK_BYPASS;
    end else if (cfg.run) begin
      l_n.mode = LK_PLAY;
    end else begin
      l_n.mode = LK_IDLE;
    end

    case (cfg.fmt[`CAVPB_FMT_LEN_HI:`CAVPB_FMT_LEN_LO])
      2'h0:    nbits = 6'h10;
      2'h1:    nbits = 6'h18;
      default: nbits = 6'h20;
    endcase
    wbits = cfg.fmt[`CAVPB_FMT_W18] ? 6'h12 : 6'h10;

    // Fixed divider of the link clock sets a constant bit clock rate; the sample rate also depends on the slot length
    l_n.div = l_q.div + 4'h1;
    if (l_q.mode != LK_PLAY) begin
      l_n.div     = 4'h0;
      l_n.phase   = 1'b0;
      l_n.bit_idx = 5'h00;
      l_n.chan    = 1'b0;
      l_n.smp_ok  = 1'b0;
    end else if (l_q.div == `CAVPB_BCK_HALF - 4'h1) begin
      l_n.div   = 4'h0;
      l_n.phase = ~l_q.phase;
      if (l_q.phase) begin
        if ({1'b0, l_q.bit_idx} == nbits - 6'h01) begin
          l_n.bit_idx = 5'h00;
          l_n.chan    = ~l_q.chan;
          if (l_q.chan) begin
            if (l_q.smp_ok) begin
              l_n.done_tgl = ~l_q.done_tgl;
            end
            l_n.smp_ok = 1'b0;
            if (l_q.tgl_s2 != l_q.ack) begin
              l_n.ack    = ~l_q.ack;
              l_n.smp_ok = 1'b1;
              case (cfg.dac[`CAVPB_DAC_MODE_HI:`CAVPB_DAC_MODE_LO])
                `CAVPB_MODE_MONO_R: l_n.smp = {s_q.xfer.right, s_q.xfer.right};
                `CAVPB_MODE_MONO_L: l_n.smp = {s_q.xfer.left, s_q.xfer.left};
                `CAVPB_MODE_SWAP:   l_n.smp = {s_q.xfer.right, s_q.xfer.left};
                default:            l_n.smp = s_q.xfer;
              endcase
            end
          end
        end else begin
          l_n.bit_idx = l_q.bit_idx + 5'h01;
        end
      end
    end

    // Left-justified words start at the word clock edge (one bit later with DLY1 set), others end at the slot end
    off = cfg.fmt[`CAVPB_FMT_LJUST] ? {6'h00, cfg.fmt[`CAVPB_FMT_DLY1]}
                                    : $signed({1'b0, nbits}) - $signed({1'b0, wbits});
    pos = $signed({2'h0, l_n.bit_idx}) - off;
    sel = cfg.fmt[`CAVPB_FMT_LSBF] ? $signed({1'b0, 6'h12 - wbits}) + pos : 7'sh11 - pos;
    chd    = l_n.chan ? l_n.smp.right : l_n.smp.left;
    chmute = l_n.chan ? cfg.dac[`CAVPB_DAC_RMUTE] : cfg.dac[`CAVPB_DAC_LMUTE];
    serial_bit = 1'b0;
    if (pos >= 7'sh00 && pos < $signed({1'b0, wbits}) && l_n.smp_ok && !chmute) begin
      serial_bit = chd[sel[4:0]];
    end

    l_n.oen_n = 3'h0;
    l_n.dau   = 1'b0;
    case (l_q.mode)
      LK_PLAY: begin
        l_n.wck = l_n.chan ^ cfg.fmt[`CAVPB_FMT_LHIGH];
        l_n.bck = l_n.phase ^ cfg.fmt[`CAVPB_FMT_BCKF];
        l_n.dat = serial_bit;
        l_n.dau = serial_bit & cfg.clk[`CAVPB_CLK_DIGITAL_AUDIO_ENABLE];
      end
      LK_BYPASS: begin
        // Swap is done by flipping the word clock; mute follows the output slot
        l_n.wck = l_q.dsp_s2[2] ^ swap;
        l_n.bck = l_q.dsp_s2[1];
        l_n.dat = l_q.dsp_s2[0] & ~((l_q.dsp_s2[2] ^ swap) ? cfg.dac[`CAVPB_DAC_LMUTE]
                                                           : cfg.dac[`CAVPB_DAC_RMUTE]);
      end
      LK_GPIO: begin
        {l_n.wck, l_n.bck, l_n.dat} = cfg.gpio_out;
        l_n.oen_n = cfg.gpio_oen_n;
      end
      default: begin
        l_n.wck = cfg.fmt[`CAVPB_FMT_LHIGH];
        l_n.bck = cfg.fmt[`CAVPB_FMT_BCKF];
        l_n.dat = 1'b0;
      end
    endcase
  end

  always_ff @(posedge audio_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      l_q       <= '0;
      l_q.mode  <= LK_GPIO;
      l_q.oen_n <= 3'h7;
    end else begin
      l_q <= l_n;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata_o                = s_q.rdata;
  assign dac_block_done_o           = s_q.blk_evt;
  assign dac_block_done_flag_o      = s_q.flag;
  assign mem_req_o                  = s_q.mem_req;
  assign mem_addr_o                 = s_q.mem_addr;
  assign gpio_in_o                  = s_q.gpin_s2;
  assign audio_word_clock_out_o     = l_q.wck;
  assign audio_bit_clock_out_o      = l_q.bck;
  assign audio_serial_data_out_o    = l_q.dat;
  assign audio_word_clock_oen_n_o   = l_q.oen_n[2];
  assign audio_bit_clock_oen_n_o    = l_q.oen_n[1];
  assign audio_serial_data_oen_n_o  = l_q.oen_n[0];
  assign digital_audio_output_pin_o = l_q.dau;

endmodule // cavpb_top

// file: tb/cavpb_assertions.sv
`timescale 1ns/1ps
// ****************************************************************
// Port protocol checks
// ****************************************************************
module cavpb_assertions (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        cav_mode_i,
  input wire logic        dac_block_done_mask_i,
  input wire logic        dac_block_done_clear_i,
  input wire logic        dac_block_done_o,
  input wire logic        dac_block_done_flag_o,
  input wire logic        mem_req_o,
  input wire logic [17:0] mem_addr_o,
  input wire logic        mem_ack_i,
  input wire logic [2:0]  gpio_out_i,
  input wire logic [2:0]  gpio_oen_n_i,
  input wire logic        audio_word_clock_out_o,
  input wire logic        audio_word_clock_oen_n_o,
  input wire logic        audio_bit_clock_out_o,
  input wire logic        audio_bit_clock_oen_n_o,
  input wire logic        audio_serial_data_out_o,
  input wire logic        audio_serial_data_oen_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire logic [2:0] oen_n = {audio_word_clock_oen_n_o, audio_bit_clock_oen_n_o, audio_serial_data_oen_n_o};
  wire logic [2:0] outs  = {audio_word_clock_out_o, audio_bit_clock_out_o, audio_serial_data_out_o};
  // Six system cycles span well over the link-side settling delay
  sequence s_gpio_steady;
    (!cav_mode_i && $stable(gpio_out_i) && $stable(gpio_oen_n_i)) [*6];
  endsequence
  sequence s_clear_quiet;
    !dac_block_done_o ##1 (dac_block_done_clear_i && !dac_block_done_o) ##1 !dac_block_done_o;
  endsequence
  chk_gpio_enable: assert property (s_gpio_steady |-> oen_n == gpio_oen_n_i)
    else $error("pin enables do not follow gpio enables");
  chk_gpio_level: assert property (s_gpio_steady |-> (outs | gpio_oen_n_i) == (gpio_out_i | gpio_oen_n_i))
    else $error("pin levels do not follow gpio values");
  chk_cav_drive: assert property (cav_mode_i [*6] |-> oen_n == 3'h0)
    else $error("audio pins not driven in cav mode");
  chk_req_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
    else $error("fetch request dropped or changed before ack");
  chk_req_drop: assert property (mem_ack_i |=> !mem_req_o)
    else $error("fetch request stays after ack");
  chk_req_cav: assert property ($rose(mem_req_o) |-> cav_mode_i)
    else $error("fetch started outside cav mode");
  chk_event_one: assert property (dac_block_done_o |=> !dac_block_done_o)
    else $error("block event longer than one cycle");
  chk_flag_set: assert property (dac_block_done_o && dac_block_done_mask_i |-> ##[0:1] dac_block_done_flag_o)
    else $error("flag not set by enabled event");
  chk_flag_cause: assert property ($rose(dac_block_done_flag_o) |->
    (dac_block_done_o && dac_block_done_mask_i) || $past(dac_block_done_o && dac_block_done_mask_i))
    else $error("flag set without enabled event");
  chk_flag_clear: assert property (s_clear_quiet |-> !dac_block_done_flag_o)
    else $error("flag not cleared");
  chk_flag_sticky: assert property (dac_block_done_flag_o && !dac_block_done_clear_i |=> dac_block_done_flag_o)
    else $error("flag lost without clear");
endmodule // cavpb_assertions

// file: tb/cavpb_dac_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Receiving converter: marks which slots carried signal
// ****************************************************************
module cavpb_dac_model (
  input  wire logic       wck_i,
  input  wire logic       bck_i,
  input  wire logic       dat_i,
  input  wire logic [7:0] fmt_i,
  input  wire logic       clr_i,
  output logic            hot_l_o,
  output logic            hot_r_o
);
  int ones;
  initial begin
    ones = 0;
    hot_l_o = 0;
    hot_r_o = 0;
  end
  // Sample on the bit clock edge opposite the one that launches data
  always @(bck_i) begin
    if (bck_i != fmt_i[0] && dat_i) ones++;
  end
  // Eight ones in a slot count as signal, so a one-bit framing skew is harmless
  // The slot just closed was left when the word clock leaves the left level
  always @(wck_i) begin
    if (ones >= 8 && wck_i != fmt_i[1]) hot_l_o = 1;
    if (ones >= 8 && wck_i == fmt_i[1]) hot_r_o = 1;
    ones = 0;
  end
  always @(posedge clr_i) begin
    hot_l_o = 0;
    hot_r_o = 0;
  end
endmodule // cavpb_dac_model

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top import cavpb_pkg::*;;
  logic clk_i = 0, rstn_i = 0, audio_clk_i = 0;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, rdata;
  logic reg_wr_i = 0, reg_rd_i = 0, inc = 0, srst = 0, cav = 0, mask = 0, clr = 0, mon_clr = 0, ack = 0;
  logic [2:0] g_out = 0, g_oen = 3'h7, ext = 0, dsp = 0, oen_n, outs, pins, gin;
  logic done, flag, req, dau, hl, hr;
  logic [17:0] addr;
  logic [7:0] mdl [8'h48:8'h4E], msk [8'h48:8'h4E];
  logic [7:0] fmts [5] = '{8'h12, 8'h92, 8'h70, 8'hF0, 8'h07};
  int n_fail = 0, tests_run = 0, dau_ones = 0, i;
  assign pins = (ext & oen_n) | (outs & ~oen_n);
  always #25 clk_i = ~clk_i;
  always #6 audio_clk_i = ~audio_clk_i;
  cavpb_top dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .audio_clk_i(audio_clk_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rdata),
    .increment_block_count_i(inc), .soft_reset_i(srst), .cav_mode_i(cav), .dac_block_done_mask_i(mask),
    .dac_block_done_clear_i(clr), .dac_block_done_o(done), .dac_block_done_flag_o(flag), .mem_req_o(req),
    .mem_addr_o(addr), .mem_ack_i(ack), .mem_data_i({18'h3FFFC, 18'h00000}), .dsp_lrck_i(dsp[2]),
    .dsp_bck_i(dsp[1]), .dsp_data_i(dsp[0]), .gpio_out_i(g_out), .gpio_oen_n_i(g_oen), .gpio_in_o(gin),
    .audio_word_clock_pin_i(pins[2]), .audio_bit_clock_pin_i(pins[1]), .audio_serial_data_pin_i(pins[0]),
    .audio_word_clock_out_o(outs[2]), .audio_word_clock_oen_n_o(oen_n[2]), .audio_bit_clock_out_o(outs[1]),
    .audio_bit_clock_oen_n_o(oen_n[1]), .audio_serial_data_out_o(outs[0]),
    .audio_serial_data_oen_n_o(oen_n[0]), .digital_audio_output_pin_o(dau));
  cavpb_dac_model dac_u (.wck_i(outs[2]), .bck_i(outs[1]), .dat_i(outs[0]), .fmt_i(mdl[8'h4C]),
    .clr_i(mon_clr), .hot_l_o(hl), .hot_r_o(hr));
  always @(posedge outs[1]) if (dau) dau_ones++;
  // Memory side answers after a random wait; one word outstanding
  always @(posedge clk_i) begin
    #2;
    if (req && !ack && $urandom_range(1)) begin
      ack = 1;
      chk("fetch block", addr[17:10], mdl[8'h4A]);
    end else ack = 0;
  end
  task chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task automatic pulse(ref logic s);
    cyc(1);
    s = 1;
    cyc(1);
    s = 0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
    cyc(1);
    reg_wr_i = 0;
    if (a inside {[8'h48:8'h4E]}) mdl[a] = d & msk[a];
  endtask
  task rdc(input logic [7:0] a);
    cyc(1);
    {reg_addr_i, reg_rd_i} = {a, 1'b1};
    cyc(1);
    reg_rd_i = 0;
    cyc(1);
    chk($sformatf("reg %h", a), rdata, mdl[a]);
  endtask
  task conclude;
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #5000000;
    n_fail++;
    conclude();
  end
  initial begin
    void'($urandom(32'hF06C07BA));
    for (i = 8'h48; i <= 8'h4E; i++) {mdl[i], msk[i]} = {8'h00, 8'h00};
    {mdl[8'h4C], mdl[8'h4D], mdl[8'h4E]} = {8'h12, 8'hC0, 8'h01};
    {msk[8'h48], msk[8'h4A], msk[8'h4C], msk[8'h4D], msk[8'h4E]} = {8'hFF, 8'hFF, 8'hFF, 8'hC7, 8'h63};
    cyc(12);
    rstn_i = 1;
    for (i = 8'h48; i <= 8'h4E; i++) rdc(i);
    for (i = 8'h48; i <= 8'h4E; i++) begin
      wr(i, $urandom);
      rdc(i);
    end
    pulse(srst);
    mdl[8'h4D] |= 8'hC0;
    rdc(8'h4D);
    repeat (3) begin
      {g_out, g_oen, ext} = $urandom;
      cyc(10);
      chk("gpio enables", oen_n, g_oen);
      chk("gpio inputs", gin, (ext & g_oen) | (g_out & ~g_oen));
    end
    wr(8'h48, 8'h00);
    pulse(inc);
    mdl[8'h48]++;
    rdc(8'h48);
    wr(8'h4A, 8'hFF);
    wr(8'h4C, 8'h02);
    wr(8'h4E, 8'h21);
    {cav, mask} = 2'b11;
    // Stereo, mono right, mono left, swap, then mono left with left muted; a new output format each time
    for (i = 0; i < 5; i++) begin
      wr(8'h4C, fmts[i]);
      wr(8'h4D, (i < 4) ? {5'h00, i[1:0], 1'b1} : 8'h85);
      cyc(300);
      pulse(mon_clr);
      cyc(600);
      chk("left slot", hl, (5'h05 >> i) & 5'h01);
      chk("right slot", hr, (5'h1C >> i) & 5'h01);
      chk("pins driven", oen_n, 3'h0);
    end
    chk("digital copy", dau_ones > 0, 1'b1);
    wr(8'h4D, 8'h01);
    i = 0;
    while (done !== 1'b1 && i < 40000) begin
      @(posedge clk_i);
      #1;
      i++;
    end
    chk("block done", i < 40000, 1'b1);
    {mdl[8'h48], mdl[8'h4A]} = {8'h00, 8'h00};
    cyc(3);
    rdc(8'h48);
    rdc(8'h4A);
    chk("flag", flag, 1'b1);
    pulse(mon_clr);
    cyc(600);
    chk("under-run left", hl, 1'b0);
    chk("under-run right", hr, 1'b0);
    pulse(inc);
    mdl[8'h48]++;
    cyc(300);
    pulse(mon_clr);
    cyc(600);
    chk("resume left", hl, 1'b1);
    pulse(clr);
    cyc(2);
    chk("flag cleared", flag, 1'b0);
    wr(8'h4E, 8'h40);
    wr(8'h4D, 8'h00);
    repeat (4) begin
      dsp = $urandom;
      cyc(4);
      chk("bypass pins", outs, dsp);
    end
    conclude();
  end
endmodule // tb_top
bind cavpb_top cavpb_assertions chk_u (.clk_i, .rstn_i, .cav_mode_i, .dac_block_done_mask_i,
  .dac_block_done_clear_i, .dac_block_done_o, .dac_block_done_flag_o, .mem_req_o, .mem_addr_o, .mem_ack_i,
  .gpio_out_i, .gpio_oen_n_i, .audio_word_clock_out_o, .audio_word_clock_oen_n_o, .audio_bit_clock_out_o,
  .audio_bit_clock_oen_n_o, .audio_serial_data_out_o, .audio_serial_data_oen_n_o);
